// [rtc_buffered_timekeeper_tb.sv]
// Self-checking bench for the buffered real-time clock
`timescale 1ns/100ps
`default_nettype none
module rtc_buffered_timekeeper_tb;
	// Short second keeps the run brief
	localparam int TPS = 32;
	localparam int SEC_CYC = TPS * rtcbt_pkg::TICK_DIV;
	logic clock;
	logic srst;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic momentary_loss_recovery;
	logic irq;
	logic [7:0] rdv;
	int miscompares;
	int checked;

	rtcbt_top #(.TICKS_PER_SEC(TPS)) rtcbt_top_inst (
		.clock(clock),
		.srst(srst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.momentary_loss_recovery(momentary_loss_recovery),
		.irq(irq)
	);

	// 10 MHz system clock
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// Verdict and end of run
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Byte compare
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Single-bit compare
	task automatic chk1(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	// One-cycle read strobe, data taken in the following cycle
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		rdv = reg_rdata;
	endtask

	// Read and compare the masked value
	task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		rd(a);
		chk8(rdv & m, e);
	endtask

	// Seven consecutive field writes
	task automatic wr_fields(input logic [7:0] base, input logic [7:0] v [7]);
		for (int i = 0; i < 7; i++) begin
			wr(base + 8'(i), v[i]);
		end
	endtask

	// Raise a request bit, see it pending, poll until it clears itself
	task automatic req(input logic [7:0] m);
		int n;
		n = 0;
		wr(rtcbt_pkg::ADR_UPDATE, m);
		rdchk(rtcbt_pkg::ADR_UPDATE, m, m);
		while ((rdv & m) !== 8'h00 && n < 1000) begin
			rd(rtcbt_pkg::ADR_UPDATE);
			n++;
		end
		chk8(rdv & m, 8'h00);
	endtask

	// Bounded wait for the interrupt line
	task automatic wait_irq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < SEC_CYC + 1000) begin
			@(posedge clock);
			#1;
			n++;
		end
	endtask

	// Hang guard, well beyond the roughly seven seconds the tests need
	initial begin
		repeat (9 * SEC_CYC) @(posedge clock);
		miscompares++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		srst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		momentary_loss_recovery = 1'b0;
		repeat (5) @(posedge clock);
		srst <= 1'b0;
		rdchk(rtcbt_pkg::ADR_UPDATE, 8'hFF, 8'h00);
		rdchk(8'h30, 8'hFF, 8'h00);
		// Buffered write does not reach the read side
		wr(rtcbt_pkg::ADR_SEC, 8'h30);
		rdchk(rtcbt_pkg::ADR_SEC, 8'hFF, 8'h00);
		req(8'h01);
		rdchk(rtcbt_pkg::ADR_SEC, 8'hFF, 8'h00);
		req(8'h10);
		rdchk(rtcbt_pkg::ADR_SEC, 8'hFF, 8'h30);
		// Snapshot stays frozen while the counter moves on
		repeat (SEC_CYC + 200) @(posedge clock);
		rdchk(rtcbt_pkg::ADR_SEC, 8'hFF, 8'h30);
		// Second commit copies only the minute
		wr(rtcbt_pkg::ADR_SEC + 8'h01, 8'h15);
		req(8'h01);
		req(8'h10);
		rdchk(rtcbt_pkg::ADR_SEC, 8'hFF, 8'h31);
		rdchk(rtcbt_pkg::ADR_SEC + 8'h01, 8'hFF, 8'h15);
		// Seconds interrupt enabled, raised and cleared
		wr(rtcbt_pkg::ADR_INT_CLEAR, 8'h1F);
		wr(rtcbt_pkg::ADR_INT_ENABLE, 8'h01);
		req(8'h01);
		chk1(irq, 1'b0);
		wait_irq();
		chk1(irq, 1'b1);
		rdchk(rtcbt_pkg::ADR_INT_FLAGS, 8'h01, 8'h01);
		wr(rtcbt_pkg::ADR_INT_CLEAR, 8'h01);
		@(posedge clock);
		#1;
		chk1(irq, 1'b0);
		// Masked flags do not reach the line
		wr(rtcbt_pkg::ADR_INT_ENABLE, 8'h00);
		req(8'h01);
		repeat (SEC_CYC + 200) @(posedge clock);
		#1;
		chk1(irq, 1'b0);
		rdchk(rtcbt_pkg::ADR_INT_FLAGS, 8'h01, 8'h01);
		@(posedge clock);
		momentary_loss_recovery <= 1'b1;
		repeat (5) @(posedge clock);
		rdchk(rtcbt_pkg::ADR_INT_FLAGS, 8'h10, 8'h10);
		chk1(irq, 1'b0);
		wr(rtcbt_pkg::ADR_INT_ENABLE, 8'h10);
		req(8'h01);
		chk1(irq, 1'b1);
		@(posedge clock);
		momentary_loss_recovery <= 1'b0;
		wr(rtcbt_pkg::ADR_INT_CLEAR, 8'h1F);
		@(posedge clock);
		#1;
		chk1(irq, 1'b0);
		// Leap February in BCD 24-hour, alarm 1 at midnight
		wr(rtcbt_pkg::ADR_CTRL, 8'h02);
		wr_fields(rtcbt_pkg::ADR_SEC, '{8'h59, 8'h59, 8'h23, 8'h03, 8'h02, 8'h24, 8'h28});
		wr_fields(rtcbt_pkg::ADR_ALM1, '{8'h00, 8'h00, 8'h00, 8'h04, 8'h02, 8'h24, 8'h29});
		req(8'h01);
		repeat (SEC_CYC + 400) @(posedge clock);
		req(8'h10);
		rdchk(rtcbt_pkg::ADR_DOM, 8'hFF, 8'h29);
		rdchk(rtcbt_pkg::ADR_SEC + 8'h04, 8'hFF, 8'h02);
		rdchk(rtcbt_pkg::ADR_SEC + 8'h02, 8'hFF, 8'h00);
		rdchk(rtcbt_pkg::ADR_SEC + 8'h03, 8'hFF, 8'h04);
		rdchk(rtcbt_pkg::ADR_INT_FLAGS, 8'h0E, 8'h06);
		// Common-year February in binary 24-hour
		wr(rtcbt_pkg::ADR_CTRL, 8'h03);
		wr_fields(rtcbt_pkg::ADR_SEC, '{8'h3B, 8'h3B, 8'h17, 8'h03, 8'h02, 8'h17, 8'h1C});
		wr_fields(rtcbt_pkg::ADR_ALM2, '{8'h00, 8'h00, 8'h00, 8'h04, 8'h03, 8'h17, 8'h01});
		wr(rtcbt_pkg::ADR_INT_CLEAR, 8'h1F);
		req(8'h01);
		repeat (SEC_CYC + 400) @(posedge clock);
		req(8'h10);
		rdchk(rtcbt_pkg::ADR_SEC + 8'h04, 8'hFF, 8'h03);
		rdchk(rtcbt_pkg::ADR_DOM, 8'hFF, 8'h01);
		rdchk(rtcbt_pkg::ADR_SEC + 8'h02, 8'hFF, 8'h00);
		rdchk(rtcbt_pkg::ADR_INT_FLAGS, 8'h0C, 8'h08);
		// 12-hour BCD: 11:59:59 AM rolls to 12 PM
		wr(rtcbt_pkg::ADR_CTRL, 8'h00);
		wr(rtcbt_pkg::ADR_SEC, 8'h59);
		wr(rtcbt_pkg::ADR_SEC + 8'h01, 8'h59);
		wr(rtcbt_pkg::ADR_SEC + 8'h02, 8'h11);
		req(8'h01);
		repeat (SEC_CYC + 400) @(posedge clock);
		req(8'h10);
		rdchk(rtcbt_pkg::ADR_SEC + 8'h02, 8'hFF, 8'h52);
		rdchk(rtcbt_pkg::ADR_SEC + 8'h01, 8'hFF, 8'h00);
		// Binary 12-hour view of the same noon hour
		wr(rtcbt_pkg::ADR_CTRL, 8'h01);
		req(8'h01);
		req(8'h10);
		rdchk(rtcbt_pkg::ADR_SEC + 8'h02, 8'hFF, 8'h4C);
		tally_and_finish();
	end
endmodule
`default_nettype wire

// [rtcbt_calendar.sv]
// Binary calendar counters with per-field load
`timescale 1ns/100ps
`default_nettype none
module rtcbt_calendar (
	input wire logic clock,
	input wire logic srst,
	input wire logic step,
	input wire logic [rtcbt_pkg::NUM_FIELDS-1:0] load_mask,
	input wire logic [7:0] load_val [rtcbt_pkg::NUM_FIELDS],
	output logic [7:0] cnt [rtcbt_pkg::NUM_FIELDS],
	output logic minute_pulse
);
	logic [7:0] next_cnt [rtcbt_pkg::NUM_FIELDS];
	logic next_minute_pulse;

	// Month length with leap correction for years 2000 to 2099
	function automatic logic [7:0] month_days(input logic [7:0] mon, input logic [7:0] yr);
		case (mon)
			rtcbt_pkg::MON_FEB: month_days = (yr[1:0] == 2'b00) ?
				rtcbt_pkg::DAYS_FEB_LEAP : rtcbt_pkg::DAYS_FEB;
			8'h04, 8'h06, 8'h09, 8'h0B: month_days = rtcbt_pkg::DAYS_SHORT;
			default: month_days = rtcbt_pkg::DAYS_LONG;
		endcase
	endfunction

	// Ripple carry from seconds up to years, then loads override
	always_comb begin
		next_cnt = cnt;
		next_minute_pulse = 1'b0;
		if (step) begin
			if (cnt[rtcbt_pkg::F_SEC] == rtcbt_pkg::SEC_MAX) begin
				next_cnt[rtcbt_pkg::F_SEC] = 8'h00;
				next_minute_pulse = 1'b1;
				if (cnt[rtcbt_pkg::F_MIN] == rtcbt_pkg::MIN_MAX) begin
					next_cnt[rtcbt_pkg::F_MIN] = 8'h00;
					if (cnt[rtcbt_pkg::F_HOUR] == rtcbt_pkg::HOUR_MAX) begin
						next_cnt[rtcbt_pkg::F_HOUR] = 8'h00;
						next_cnt[rtcbt_pkg::F_DOW] = (cnt[rtcbt_pkg::F_DOW] == rtcbt_pkg::DOW_MAX) ?
							8'h00 : cnt[rtcbt_pkg::F_DOW] + 8'h01;
						if (cnt[rtcbt_pkg::F_DOM] == month_days(cnt[rtcbt_pkg::F_MON],
							cnt[rtcbt_pkg::F_YEAR])) begin
							next_cnt[rtcbt_pkg::F_DOM] = rtcbt_pkg::FIRST_DAY;
							if (cnt[rtcbt_pkg::F_MON] == rtcbt_pkg::MON_MAX) begin
								next_cnt[rtcbt_pkg::F_MON] = rtcbt_pkg::FIRST_DAY;
								next_cnt[rtcbt_pkg::F_YEAR] = (cnt[rtcbt_pkg::F_YEAR] ==
									rtcbt_pkg::YEAR_MAX) ? 8'h00 : cnt[rtcbt_pkg::F_YEAR] + 8'h01;
							end else begin
								next_cnt[rtcbt_pkg::F_MON] = cnt[rtcbt_pkg::F_MON] + 8'h01;
							end
						end else begin
							next_cnt[rtcbt_pkg::F_DOM] = cnt[rtcbt_pkg::F_DOM] + 8'h01;
						end
					end else begin
						next_cnt[rtcbt_pkg::F_HOUR] = cnt[rtcbt_pkg::F_HOUR] + 8'h01;
					end
				end else begin
					next_cnt[rtcbt_pkg::F_MIN] = cnt[rtcbt_pkg::F_MIN] + 8'h01;
				end
			end else begin
				next_cnt[rtcbt_pkg::F_SEC] = cnt[rtcbt_pkg::F_SEC] + 8'h01;
			end
		end
		for (int k = 0; k < rtcbt_pkg::NUM_FIELDS; k++) begin
			if (load_mask[k]) begin
				next_cnt[k] = load_val[k];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			for (int k = 0; k < rtcbt_pkg::NUM_FIELDS; k++) begin
				cnt[k] <= 8'h00;
			end
			cnt[rtcbt_pkg::F_MON] <= rtcbt_pkg::FIRST_DAY;
			cnt[rtcbt_pkg::F_DOM] <= rtcbt_pkg::FIRST_DAY;
			minute_pulse <= 1'b0;
		end else begin
			cnt <= next_cnt;
			minute_pulse <= next_minute_pulse;
		end
	end
endmodule
`default_nettype wire

// [rtcbt_pkg.sv]
// Shared constants for the buffered real-time clock
package rtcbt_pkg;
	// Clock rates and the slow-tick divider
	localparam int CLK_HZ = 10_000_000;
	localparam int SLOW_HZ = 32768;
	localparam int TICK_DIV = CLK_HZ / SLOW_HZ;
	localparam logic [8:0] TICK_DIV_LAST = 9'(TICK_DIV - 1);
	localparam int SNAP_WAIT_MS = 16;

	// Register addresses
	localparam logic [7:0] ADR_INT_FLAGS = 8'h00;
	localparam logic [7:0] ADR_INT_ENABLE = 8'h01;
	localparam logic [7:0] ADR_CTRL = 8'h03;
	localparam logic [7:0] ADR_UPDATE = 8'h04;
	localparam logic [7:0] ADR_SEC = 8'h07;
	localparam logic [7:0] ADR_DOM = 8'h0D;
	localparam logic [7:0] ADR_ALM1 = 8'h0E;
	localparam logic [7:0] ADR_ALM2 = 8'h15;
	localparam logic [7:0] ADR_BUF_FIRST = 8'h01;
	localparam logic [7:0] ADR_BUF_LAST = 8'h24;
	localparam logic [7:0] ADR_INT_CLEAR = 8'h26;
	localparam int NUM_BUF = 36;
	localparam int NUM_FIELDS = 7;

	// Bit positions
	localparam int UPD_COMMIT_BIT = 0;
	localparam int UPD_SNAP_BIT = 4;
	localparam int CTRL_BIN_BIT = 0;
	localparam int CTRL_24H_BIT = 1;
	localparam int HOUR_PM_BIT = 6;
	localparam int NUM_INT = 5;
	localparam int INT_SEC = 0;
	localparam int INT_MIN = 1;
	localparam int INT_ALM1 = 2;
	localparam int INT_ALM2 = 3;
	localparam int INT_LOSS = 4;

	// Calendar field order, matching the register order
	localparam int F_SEC = 0;
	localparam int F_MIN = 1;
	localparam int F_HOUR = 2;
	localparam int F_DOW = 3;
	localparam int F_MON = 4;
	localparam int F_YEAR = 5;
	localparam int F_DOM = 6;

	// Calendar limits and reset values
	localparam logic [7:0] SEC_MAX = 8'h3B;
	localparam logic [7:0] MIN_MAX = 8'h3B;
	localparam logic [7:0] HOUR_MAX = 8'h17;
	localparam logic [7:0] DOW_MAX = 8'h06;
	localparam logic [7:0] MON_MAX = 8'h0C;
	localparam logic [7:0] YEAR_MAX = 8'h63;
	localparam logic [7:0] MON_FEB = 8'h02;
	localparam logic [7:0] DAYS_LONG = 8'h1F;
	localparam logic [7:0] DAYS_SHORT = 8'h1E;
	localparam logic [7:0] DAYS_FEB = 8'h1C;
	localparam logic [7:0] DAYS_FEB_LEAP = 8'h1D;
	localparam logic [7:0] FIRST_DAY = 8'h01;
	localparam logic [7:0] HOUR_NOON = 8'h0C;
	localparam logic [7:0] DEC_TEN = 8'h0A;

	// Locations that sit behind write and read buffers
	function automatic logic is_buf(input logic [7:0] a);
		return (a >= ADR_BUF_FIRST) && (a <= ADR_BUF_LAST) && (a != ADR_UPDATE);
	endfunction

	// Number coding between binary counters and register format
	function automatic logic [7:0] num_enc(input logic [7:0] v, input logic bin);
		logic [7:0] t;
		logic [7:0] o;
		t = v / DEC_TEN;
		o = v % DEC_TEN;
		return bin ? v : {t[3:0], o[3:0]};
	endfunction

	function automatic logic [7:0] num_dec(input logic [7:0] v, input logic bin);
		logic [7:0] t;
		t = {4'h0, v[7:4]} * DEC_TEN;
		return bin ? v : t + {4'h0, v[3:0]};
	endfunction

	// Field coding, with 12-hour form and PM flag for hours
	function automatic logic [7:0] field_enc(input int k, input logic [7:0] v,
		input logic bin, input logic h24);
		logic [7:0] h12;
		logic [7:0] r;
		h12 = (v == 8'h00) ? HOUR_NOON : ((v > HOUR_NOON) ? v - HOUR_NOON : v);
		r = num_enc(v, bin);
		if (k == F_HOUR && !h24) begin
			r = num_enc(h12, bin);
			r[HOUR_PM_BIT] = (v >= HOUR_NOON);
		end
		return r;
	endfunction

	function automatic logic [7:0] field_dec(input int k, input logic [7:0] v,
		input logic bin, input logic h24);
		logic [7:0] vm;
		logic [7:0] h12;
		logic pm;
		logic [7:0] r;
		vm = v;
		vm[HOUR_PM_BIT] = 1'b0;
		pm = v[HOUR_PM_BIT];
		h12 = num_dec(vm, bin);
		r = num_dec(v, bin);
		if (k == F_HOUR && !h24) begin
			if (h12 == HOUR_NOON) begin
				r = pm ? HOUR_NOON : 8'h00;
			end else begin
				r = pm ? h12 + HOUR_NOON : h12;
			end
		end
		return r;
	endfunction
endpackage

// [rtcbt_sync.sv]
// Two-stage synchroniser advanced by an enable pulse
`timescale 1ns/100ps
`default_nettype none
module rtcbt_sync (
	input wire logic clock,
	input wire logic srst,
	input wire logic en,
	input wire logic d,
	output logic q
);
	logic stage1;
	logic next_stage1;
	logic next_q;

	// First stage feeds only the second
	always_comb begin
		next_stage1 = stage1;
		next_q = q;
		if (en) begin
			next_stage1 = d;
			next_q = stage1;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			stage1 <= 1'b0;
			q <= 1'b0;
		end else begin
			stage1 <= next_stage1;
			q <= next_q;
		end
	end
endmodule
`default_nettype wire

// [rtcbt_top.sv]
// Buffered real-time clock: register file, transfers, alarms, interrupts
//
// Contract
// - Buffered registers except flags and request bits
// - Writes touch only write buffer, mark modified
// - Commit bit copies modified buffers to live
// - Commit done clears request and modified marks
// - Commit bit synchronised twice before transfer
// - Reads return read buffers, not live counters
// - Snapshot bit copies live timing into buffers
// - Snapshot done clears snapshot request bit
// - Synchronised snapshot bit strobes read buffers
// - Gregorian calendar with leap-year February
// - Two independent seven-field alarms
// - Binary or BCD; 12 or 24 hour
// - Maskable tick, minute, alarm, loss interrupts
//
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module rtcbt_top #(
	parameter int TICKS_PER_SEC = 32768
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic momentary_loss_recovery,
	output logic irq
);
	localparam int NB = rtcbt_pkg::NUM_BUF;
	localparam int NF = rtcbt_pkg::NUM_FIELDS;
	localparam logic [15:0] SUB_LAST = 16'(TICKS_PER_SEC - 1);

	logic [8:0] div_cnt, next_div_cnt;
	logic tick, next_tick;
	logic [15:0] sub_cnt, next_sub_cnt;
	logic sec_pulse, next_sec_pulse;
	logic sec_d;
	logic commit_req, next_commit_req;
	logic snap_req, next_snap_req;
	logic commit_sync, snapshot_strobe_synced, loss_sync, loss_d;
	logic commit_fire, snap_fire, upd_wr;
	logic [7:0] wbuf [1:NB];
	logic [7:0] next_wbuf [1:NB];
	logic [NB:1] wmod, next_wmod;
	logic [7:0] live [1:NB];
	logic [7:0] next_live [1:NB];
	logic [7:0] rbuf [1:NB];
	logic [7:0] next_rbuf [1:NB];
	logic [7:0] cnt [NF];
	logic [7:0] view [NF];
	logic [7:0] load_val [NF];
	logic [NF-1:0] load_mask;
	logic [7:0] ctrl_eff;
	logic minute_pulse, alm1_hit, alm2_hit;
	logic [rtcbt_pkg::NUM_INT-1:0] rtc_interrupt_flags, next_flags, int_event, int_clear;
	logic [7:0] next_rdata;

	// Slow tick enable and one-second pulse
	always_comb begin
		next_tick = (div_cnt == rtcbt_pkg::TICK_DIV_LAST);
		next_div_cnt = next_tick ? 9'h000 : div_cnt + 9'h001;
		next_sec_pulse = 1'b0;
		next_sub_cnt = sub_cnt;
		if (tick) begin
			next_sec_pulse = (sub_cnt == SUB_LAST);
			next_sub_cnt = next_sec_pulse ? 16'h0000 : sub_cnt + 16'h0001;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			div_cnt <= 9'h000;
			tick <= 1'b0;
			sub_cnt <= 16'h0000;
			sec_pulse <= 1'b0;
			sec_d <= 1'b0;
			loss_d <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			tick <= next_tick;
			sub_cnt <= next_sub_cnt;
			sec_pulse <= next_sec_pulse;
			sec_d <= sec_pulse;
			loss_d <= loss_sync;
		end
	end

	// Request bits crossing into the slow-tick domain; the loss input synchronised on every clock
	rtcbt_sync u_commit_sync (
		.clock(clock),
		.srst(srst || commit_fire), // Flushed so a new request passes both stages again
		.en(tick),
		.d(commit_req),
		.q(commit_sync)
	);

	rtcbt_sync u_snap_sync (
		.clock(clock),
		.srst(srst || snap_fire), // Flushed so a new request passes both stages again
		.en(tick),
		.d(snap_req),
		.q(snapshot_strobe_synced)
	);

	rtcbt_sync u_loss_sync (
		.clock(clock),
		.srst(srst),
		.en(1'b1),
		.d(momentary_loss_recovery),
		.q(loss_sync)
	);

	// Transfer enables on a slow tick while a request is pending
	assign upd_wr = reg_wr && (reg_addr == rtcbt_pkg::ADR_UPDATE);
	assign commit_fire = tick && commit_sync && commit_req;
	assign snap_fire = tick && snapshot_strobe_synced && snap_req;

	// Live time view and calendar loads at commit
	assign ctrl_eff = (commit_fire && wmod[rtcbt_pkg::ADR_CTRL]) ?
		wbuf[rtcbt_pkg::ADR_CTRL] : live[rtcbt_pkg::ADR_CTRL];
	always_comb begin
		for (int k = 0; k < NF; k++) begin
			view[k] = rtcbt_pkg::field_enc(k, cnt[k],
				live[rtcbt_pkg::ADR_CTRL][rtcbt_pkg::CTRL_BIN_BIT],
				live[rtcbt_pkg::ADR_CTRL][rtcbt_pkg::CTRL_24H_BIT]);
			load_mask[k] = commit_fire && wmod[int'(rtcbt_pkg::ADR_SEC) + k];
			load_val[k] = rtcbt_pkg::field_dec(k, wbuf[int'(rtcbt_pkg::ADR_SEC) + k],
				ctrl_eff[rtcbt_pkg::CTRL_BIN_BIT], ctrl_eff[rtcbt_pkg::CTRL_24H_BIT]);
		end
	end

	rtcbt_calendar u_calendar (
		.clock(clock),
		.srst(srst),
		.step(sec_pulse),
		.load_mask(load_mask),
		.load_val(load_val),
		.cnt(cnt),
		.minute_pulse(minute_pulse)
	);

	// Alarm match on every field, checked right after each count
	always_comb begin
		alm1_hit = 1'b1;
		alm2_hit = 1'b1;
		for (int k = 0; k < NF; k++) begin
			if (live[int'(rtcbt_pkg::ADR_ALM1) + k] != view[k]) begin
				alm1_hit = 1'b0;
			end
			if (live[int'(rtcbt_pkg::ADR_ALM2) + k] != view[k]) begin
				alm2_hit = 1'b0;
			end
		end
	end

	// Buffers, live registers, request bits and read data
	always_comb begin
		next_wbuf = wbuf;
		next_live = live;
		next_rbuf = rbuf;
		next_wmod = wmod;
		next_commit_req = commit_req;
		next_snap_req = snap_req;
		next_rdata = 8'h00;
		if (commit_fire) begin
			next_commit_req = 1'b0;
			next_wmod = '0;
			for (int i = 1; i <= NB; i++) begin
				if (wmod[i]) begin
					next_live[i] = wbuf[i];
				end
			end
		end
		if (snap_fire) begin
			next_snap_req = 1'b0;
			for (int i = 1; i <= NB; i++) begin
				next_rbuf[i] = live[i];
				if (i >= int'(rtcbt_pkg::ADR_SEC) && i <= int'(rtcbt_pkg::ADR_DOM)) begin
					next_rbuf[i] = view[i - int'(rtcbt_pkg::ADR_SEC)];
				end
			end
		end
		// Host writes win over the hardware clear in the same cycle
		if (upd_wr && reg_wdata[rtcbt_pkg::UPD_COMMIT_BIT]) begin
			next_commit_req = 1'b1;
		end
		if (upd_wr && reg_wdata[rtcbt_pkg::UPD_SNAP_BIT]) begin
			next_snap_req = 1'b1;
		end
		for (int i = 1; i <= NB; i++) begin
			if (reg_wr && rtcbt_pkg::is_buf(reg_addr) && (reg_addr == 8'(i))) begin
				next_wbuf[i] = reg_wdata;
				next_wmod[i] = 1'b1;
			end
		end
		if (reg_rd) begin
			if (reg_addr == rtcbt_pkg::ADR_INT_FLAGS) begin
				next_rdata = {3'b000, rtc_interrupt_flags};
			end else if (reg_addr == rtcbt_pkg::ADR_UPDATE) begin
				next_rdata[rtcbt_pkg::UPD_COMMIT_BIT] = commit_req;
				next_rdata[rtcbt_pkg::UPD_SNAP_BIT] = snap_req;
			end else if (rtcbt_pkg::is_buf(reg_addr)) begin
				next_rdata = rbuf[reg_addr];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			for (int i = 1; i <= NB; i++) begin
				wbuf[i] <= 8'h00;
				live[i] <= 8'h00;
				rbuf[i] <= 8'h00;
			end
			wmod <= '0;
			commit_req <= 1'b0;
			snap_req <= 1'b0;
			reg_rdata <= 8'h00;
		end else begin
			wbuf <= next_wbuf;
			live <= next_live;
			rbuf <= next_rbuf;
			wmod <= next_wmod;
			commit_req <= next_commit_req;
			snap_req <= next_snap_req;
			reg_rdata <= next_rdata;
		end
	end

	// Sticky interrupt flags: an event beats a clear in the same cycle
	always_comb begin
		int_event = '0;
		int_event[rtcbt_pkg::INT_SEC] = sec_d;
		int_event[rtcbt_pkg::INT_MIN] = minute_pulse;
		int_event[rtcbt_pkg::INT_ALM1] = sec_d && alm1_hit;
		int_event[rtcbt_pkg::INT_ALM2] = sec_d && alm2_hit;
		int_event[rtcbt_pkg::INT_LOSS] = loss_sync && !loss_d;
		int_clear = (reg_wr && reg_addr == rtcbt_pkg::ADR_INT_CLEAR) ?
			reg_wdata[rtcbt_pkg::NUM_INT-1:0] : '0;
		next_flags = (rtc_interrupt_flags & ~int_clear) | int_event;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			rtc_interrupt_flags <= '0;
		end else begin
			rtc_interrupt_flags <= next_flags;
		end
	end

	assign irq = |(rtc_interrupt_flags &
		live[rtcbt_pkg::ADR_INT_ENABLE][rtcbt_pkg::NUM_INT-1:0]);

	// Slow ticks seen since the commit request was raised
	logic [1:0] commit_ticks;
	always_ff @(posedge clock) begin
		if (srst || !commit_req || commit_fire) begin
			commit_ticks <= 2'b00;
		end else if (tick && commit_ticks != 2'b11) begin
			commit_ticks <= commit_ticks + 2'b01;
		end
	end

	// Checks on transfers, buffers and interrupts
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	property p_commit_clear;
		commit_fire && !upd_wr |=> !commit_req && (wmod == '0 || $past(reg_wr));
	endproperty
	a_commit_clear: assert property (p_commit_clear) else $error("commit not cleared");

	property p_write_buffered;
		reg_wr && reg_addr == rtcbt_pkg::ADR_CTRL && !commit_fire |=>
			wbuf[rtcbt_pkg::ADR_CTRL] == $past(reg_wdata) &&
			live[rtcbt_pkg::ADR_CTRL] == $past(live[rtcbt_pkg::ADR_CTRL]) &&
			wmod[rtcbt_pkg::ADR_CTRL];
	endproperty
	a_write_buffered: assert property (p_write_buffered) else $error("write hit live");

	property p_commit_copy;
		commit_fire && wmod[rtcbt_pkg::ADR_CTRL] |=>
			live[rtcbt_pkg::ADR_CTRL] == $past(wbuf[rtcbt_pkg::ADR_CTRL]);
	endproperty
	a_commit_copy: assert property (p_commit_copy) else $error("commit copy lost");

	property p_commit_sync;
		commit_fire |-> commit_ticks >= 2'b10;
	endproperty
	a_commit_sync: assert property (p_commit_sync) else $error("commit too early");

	property p_snap_clear;
		snap_fire && !upd_wr |=> !snap_req;
	endproperty
	a_snap_clear: assert property (p_snap_clear) else $error("snapshot not cleared");

	property p_snap_copy;
		snap_fire |=> rbuf[rtcbt_pkg::ADR_SEC] == $past(view[rtcbt_pkg::F_SEC]) &&
			rbuf[rtcbt_pkg::ADR_DOM] == $past(view[rtcbt_pkg::F_DOM]);
	endproperty
	a_snap_copy: assert property (p_snap_copy) else $error("snapshot copy wrong");

	property p_frozen;
		!snap_fire |=> $stable(rbuf[rtcbt_pkg::ADR_SEC]);
	endproperty
	a_frozen: assert property (p_frozen) else $error("read buffer moved");

	property p_read_buf;
		reg_rd && reg_addr == rtcbt_pkg::ADR_SEC |=> reg_rdata == $past(rbuf[rtcbt_pkg::ADR_SEC]);
	endproperty
	a_read_buf: assert property (p_read_buf) else $error("read not from buffer");

	property p_pending_read;
		reg_rd && reg_addr == rtcbt_pkg::ADR_UPDATE |=>
			reg_rdata[rtcbt_pkg::UPD_COMMIT_BIT] == $past(commit_req) &&
			reg_rdata[rtcbt_pkg::UPD_SNAP_BIT] == $past(snap_req);
	endproperty
	a_pending_read: assert property (p_pending_read) else $error("pending bit wrong");

	property p_sec_irq;
		sec_d && live[rtcbt_pkg::ADR_INT_ENABLE][rtcbt_pkg::INT_SEC] && !reg_wr |=> irq;
	endproperty
	a_sec_irq: assert property (p_sec_irq) else $error("tick interrupt missing");

	c_commit: cover property (commit_fire);
	c_snap: cover property (snap_fire);
	c_irq: cover property ($rose(irq));
	c_alarm: cover property (sec_d && alm1_hit);
endmodule
`default_nettype wire
